// [emc_ctrl.sv]
// external memory strobe generator, reset pin logic and access select latch
`timescale 1ns/1ps
`default_nettype none
module emc_ctrl (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              reset_pin_in,
    output var  logic              reset_pin_out,
    output var  logic              reset_pin_oe,
    input  wire logic              external_access_select,
    input  wire logic              port3_bit5,
    input  wire logic [7:0]        port0_in,
    input  wire logic              wdt_overflow,
    input  wire logic [15:0]       fetch_addr,
    input  wire logic              xdata_req,
    input  wire emc_pkg::emc_xreq_t xreq,
    output var  emc_pkg::emc_pins_t pins,
    output var  logic              cpu_reset,
    output var  logic              ext_fetch,
    output var  logic              second_timer_count_input,
    output var  logic              xdata_done,
    output var  logic [7:0]        xdata_rdata
);
    // ***************************************************************
    // pin synchronisers
    // ***************************************************************
    logic [10:0] sync_level;
    emc_pin_sync #(.W(11)) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .pin   ({port0_in, port3_bit5, external_access_select, reset_pin_in}),
        .level (sync_level)
    );
    logic       pin_rst;
    logic       pin_ea;
    logic       pin_t1;
    logic [7:0] pin_p0;
    assign pin_rst = sync_level[0];
    assign pin_ea  = sync_level[1];
    assign pin_t1  = sync_level[2];
    assign pin_p0  = sync_level[10:3];

    // ***************************************************************
    // machine cycle timing
    // ***************************************************************
    emc_pkg::emc_state_t state;
    emc_pkg::emc_state_t next_state;
    logic                p2;
    logic                next_p2;

    always_comb begin
        next_p2    = ~p2;
        next_state = state;
        if (p2) begin
            unique case (state)
                emc_pkg::EMC_S1: next_state = emc_pkg::EMC_S2;
                emc_pkg::EMC_S2: next_state = emc_pkg::EMC_S3;
                emc_pkg::EMC_S3: next_state = emc_pkg::EMC_S4;
                emc_pkg::EMC_S4: next_state = emc_pkg::EMC_S5;
                emc_pkg::EMC_S5: next_state = emc_pkg::EMC_S6;
                emc_pkg::EMC_S6: next_state = emc_pkg::EMC_S1;
                default:         next_state = emc_pkg::EMC_S1;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= emc_pkg::EMC_S1;
            p2    <= 1'b0;
        end else begin
            state <= next_state;
            p2    <= next_p2;
        end
    end

    // ***************************************************************
    // reset pin and watchdog reset
    // ***************************************************************
    logic [7:0] rst_cnt;
    logic [7:0] next_rst_cnt;
    logic [7:0] wdt_cnt;
    logic [7:0] next_wdt_cnt;
    logic       pin_reset;
    logic       next_pin_reset;
    logic       ea_latched;
    logic       next_ea_latched;
    logic [2:0] por_cnt;
    logic [2:0] next_por_cnt;

    always_comb begin
        next_rst_cnt   = emc_pkg::RST_CNT_RESET;
        next_pin_reset = pin_reset & pin_rst;
        next_wdt_cnt   = wdt_cnt;
        if (pin_rst && !reset_pin_oe) begin
            next_rst_cnt = rst_cnt;
            if (rst_cnt >= 8'(emc_pkg::RST_HOLD_CYC - 1)) begin
                next_pin_reset = 1'b1;
            end else begin
                next_rst_cnt = rst_cnt + 8'h01;
            end
        end
        if (wdt_overflow) begin
            next_wdt_cnt = 8'(emc_pkg::WDT_RST_CYC);
        end else if (wdt_cnt != 8'h00) begin
            next_wdt_cnt = wdt_cnt - 8'h01;
        end
        // core held in reset until the pin filters carry real levels
        next_por_cnt    = (por_cnt != 3'h0) ? por_cnt - 3'h1 : por_cnt;
        next_ea_latched = cpu_reset ? pin_ea : ea_latched;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt    <= emc_pkg::RST_CNT_RESET;
            wdt_cnt    <= 8'h00;
            pin_reset  <= 1'b0;
            ea_latched <= 1'b1;
            por_cnt    <= 3'(emc_pkg::POR_SETTLE_CYC);
        end else begin
            por_cnt    <= next_por_cnt;
            rst_cnt    <= next_rst_cnt;
            wdt_cnt    <= next_wdt_cnt;
            pin_reset  <= next_pin_reset;
            ea_latched <= next_ea_latched;
        end
    end

    // ***************************************************************
    // strobes and bus
    // ***************************************************************
    logic               data_cyc;
    logic               next_data_cyc;
    emc_pkg::emc_xreq_t cur_req;
    emc_pkg::emc_xreq_t next_cur_req;
    emc_pkg::emc_pins_t next_pins;
    logic               next_cpu_reset;
    logic               next_ext_fetch;
    logic               next_reset_pin_oe;
    logic               t1_prev;
    logic               next_t1_count;
    logic               next_xdata_done;
    logic [7:0]         next_xdata_rdata;
    logic               ale_slot;
    logic               program_store_read_strobe_slot;
    logic               xstb_slot;

    always_comb begin
        ale_slot  = (state == emc_pkg::EMC_S1 && p2) || (state == emc_pkg::EMC_S2 && !p2) ||
                    (state == emc_pkg::EMC_S4 && p2) || (state == emc_pkg::EMC_S5 && !p2);
        program_store_read_strobe_slot = (state == emc_pkg::EMC_S2 && p2) || (state == emc_pkg::EMC_S3) ||
                    (state == emc_pkg::EMC_S5 && p2) || (state == emc_pkg::EMC_S6);
        xstb_slot = (state == emc_pkg::EMC_S2 && p2) || (state == emc_pkg::EMC_S3) ||
                    (state == emc_pkg::EMC_S4) || (state == emc_pkg::EMC_S5) ||
                    (state == emc_pkg::EMC_S6 && !p2);
        next_cpu_reset    = next_pin_reset | (next_wdt_cnt != 8'h00) | (next_por_cnt != 3'h0);
        next_reset_pin_oe = next_wdt_cnt != 8'h00;
        next_ext_fetch    = !next_ea_latched || (fetch_addr > emc_pkg::INT_CODE_TOP);
        next_t1_count     = t1_prev & ~pin_t1;
        next_data_cyc     = data_cyc;
        next_cur_req      = cur_req;
        next_xdata_done   = 1'b0;
        next_xdata_rdata  = xdata_rdata;
        next_pins         = emc_pkg::PINS_IDLE;
        if (state == emc_pkg::EMC_S6 && p2) begin
            next_data_cyc = xdata_req & ~cpu_reset;
            next_cur_req  = xreq;
            next_xdata_done = data_cyc;
        end
        if (data_cyc && !cur_req.wr && state == emc_pkg::EMC_S6 && !p2) begin
            next_xdata_rdata = pin_p0;
        end
        if (!cpu_reset) begin
            if (data_cyc) begin
                next_pins.ale    = ale_slot && (state == emc_pkg::EMC_S1 ||
                                                state == emc_pkg::EMC_S2);
                next_pins.p2_out = cur_req.addr[15:8];
                next_pins.p0_out = ale_slot ? cur_req.addr[7:0] : cur_req.wdata;
                next_pins.p0_oe  = ale_slot || cur_req.wr;
                next_pins.wr_n   = !(xstb_slot && cur_req.wr);
                next_pins.rd_n   = !(xstb_slot && !cur_req.wr);
                // program_store_read_strobe stays high for the whole data cycle
            end else begin
                next_pins.ale    = ale_slot;
                next_pins.p2_out = fetch_addr[15:8];
                next_pins.p0_out = fetch_addr[7:0];
                next_pins.p0_oe  = ale_slot && ext_fetch;
                next_pins.program_store_read_strobe_n = !(program_store_read_strobe_slot && ext_fetch);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_cyc                 <= 1'b0;
            cur_req                  <= '0;
            pins                     <= emc_pkg::PINS_IDLE;
            cpu_reset                <= 1'b1;
            ext_fetch                <= 1'b0;
            reset_pin_oe             <= 1'b0;
            reset_pin_out            <= 1'b0;
            t1_prev                  <= 1'b0;
            second_timer_count_input <= 1'b0;
            xdata_done               <= 1'b0;
            xdata_rdata              <= 8'h00;
        end else begin
            data_cyc                 <= next_data_cyc;
            cur_req                  <= next_cur_req;
            pins                     <= next_pins;
            cpu_reset                <= next_cpu_reset;
            ext_fetch                <= next_ext_fetch;
            reset_pin_oe             <= next_reset_pin_oe;
            reset_pin_out            <= next_reset_pin_oe;
            t1_prev                  <= pin_t1;
            second_timer_count_input <= next_t1_count;
            xdata_done               <= next_xdata_done;
            xdata_rdata              <= next_xdata_rdata;
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_mcycle_wrap: assert property (state == emc_pkg::EMC_S1 && !p2 |-> ##12 (state == emc_pkg::EMC_S1 && !p2))
        else $error("machine cycle is not twelve clocks");
    a_ale_rate: assert property ($rose(pins.ale) && !data_cyc && !$past(data_cyc) && !cpu_reset
                                 |-> ##6 (pins.ale || data_cyc || cpu_reset))
        else $error("address latch pulse not every six clocks");
    // pulses cut short by reset entry or release are not held to full width
    a_ale_width: assert property ($rose(pins.ale) && !p2 && !cpu_reset |=> pins.ale ##1 !pins.ale)
        else $error("address latch pulse width wrong");
    a_ale_skip: assert property (data_cyc && state == emc_pkg::EMC_S4 |-> ##1 !pins.ale [*4])
        else $error("second latch pulse not skipped in data cycle");
    a_program_store_read_strobe_skip: assert property (data_cyc && $past(data_cyc) && state != emc_pkg::EMC_S1 |-> pins.program_store_read_strobe_n)
        else $error("program strobe active in data cycle");
    a_program_store_read_strobe_internal: assert property (!ext_fetch && !$past(ext_fetch) |-> pins.program_store_read_strobe_n)
        else $error("program strobe active on internal fetch");
    a_strobe_excl: assert property (!(pins.rd_n == 1'b0 && pins.wr_n == 1'b0) && !(!pins.rd_n && !pins.program_store_read_strobe_n))
        else $error("strobes overlap");
    a_wdt_drive: assert property (wdt_overflow |=> ##1 (reset_pin_oe && reset_pin_out && cpu_reset) [*8])
        else $error("reset pin not driven after watchdog overflow");
    a_pin_reset: assert property (pin_rst && !reset_pin_oe [*8] ##1 pin_rst && !reset_pin_oe [*8]
                                  ##1 pin_rst && !reset_pin_oe [*8] ##1 pin_rst |-> ##1 cpu_reset)
        else $error("held reset pin did not reset");
    a_ea_hold: assert property (!cpu_reset && !$past(cpu_reset) |-> $stable(ea_latched))
        else $error("access select changed outside reset");
    a_rd_strobe: assert property (data_cyc && !cur_req.wr && !cpu_reset && state == emc_pkg::EMC_S3
                                  |=> !pins.rd_n)
        else $error("read strobe missing");

    c_data_read:  cover property (xdata_done && !cur_req.wr);
    c_data_write: cover property (!pins.wr_n);
    c_wdt_reset:  cover property (reset_pin_oe);
    c_ext_fetch:  cover property (!pins.program_store_read_strobe_n);
endmodule
`default_nettype wire

// [emc_pkg.sv]
// constants and carrier types for the external memory strobe and reset pin block
// Overview of operation
// - reset pin high two machine cycles with clock running enters reset
// - on watchdog overflow device drives reset pin high while internal reset lasts
// - address latch pulse runs at one sixth of oscillator rate normally
// - each external data access skips exactly one address latch pulse
// - address latch pulse marks low address byte for external latch capture
// - external code fetch strobes program store read twice per machine cycle
// - data access machine cycle suppresses both program store strobes
// - program store strobe stays inactive for internal code fetches
// - access select low in reset sends fetches 0000h to 7fffh external
// - access select high in reset runs internal except above 7fffh
// - access select sampled only during reset, ignored afterwards
// - port 3 bit 6 drives external data write strobe
// - port 3 bit 7 drives external data read strobe
// - port 3 bit 5 is second timer external count input
package emc_pkg;
    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int          OSC_PER_MCYCLE = 12;
    localparam int          RST_HOLD_MCYC  = 2;
    localparam int          RST_HOLD_CYC   = RST_HOLD_MCYC * OSC_PER_MCYCLE;
    localparam int          WDT_RST_CYC    = 2 * OSC_PER_MCYCLE;
    localparam logic [15:0] INT_CODE_TOP   = 16'h7fff;
    localparam logic [7:0]  RST_CNT_RESET  = 8'h00;
    // power-on hold, covers the pin filter latency before access select is taken
    localparam int          POR_SETTLE_CYC = 6;
    // ***************************************************************
    // types
    // ***************************************************************
    typedef enum logic [5:0] {
        EMC_S1 = 6'h01,
        EMC_S2 = 6'h02,
        EMC_S3 = 6'h04,
        EMC_S4 = 6'h08,
        EMC_S5 = 6'h10,
        EMC_S6 = 6'h20
    } emc_state_t;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } emc_xreq_t;

    typedef struct packed {
        logic       ale;
        logic       program_store_read_strobe_n;
        logic       wr_n;
        logic       rd_n;
        logic [7:0] p0_out;
        logic       p0_oe;
        logic [7:0] p2_out;
    } emc_pins_t;

    localparam emc_pins_t PINS_IDLE = '{ale: 1'b0, program_store_read_strobe_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
                                       p0_out: 8'h00, p0_oe: 1'b0, p2_out: 8'h00};
endpackage

// [emc_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module emc_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin,
    output var  logic [W-1:0] level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_level;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            level <= '0;
        end else begin
            s1    <= pin;
            s2    <= s1;
            s3    <= s2;
            level <= next_level;
        end
    end
endmodule
`default_nettype wire

// [emc_mem_model.sv]
// partner model: external code and data memory with low address latch
`timescale 1ns/1ps
`default_nettype none
module emc_mem_model (
    input  wire logic               clock,
    input  wire emc_pkg::emc_pins_t pins,
    output var  logic [7:0]         port0_in
);
    // ***************************************************************
    // latch and storage
    // ***************************************************************
    logic [7:0]  mem [0:65535];
    logic [7:0]  addr_lo = 8'h00;
    logic [7:0]  last    = 8'h00;
    wire  logic [15:0] addr;

    assign addr = {pins.p2_out, addr_lo};

    // wire level: device drive wins, else memory, else a floating bus that keeps changing
    always_comb begin
        if (pins.p0_oe) begin
            port0_in = pins.p0_out;
        end else if (!pins.rd_n) begin
            port0_in = mem[addr];
        end else if (!pins.program_store_read_strobe_n) begin
            port0_in = addr_lo ^ 8'h5a;
        end else begin
            port0_in = ~last;
        end
    end

    always @(posedge clock) begin
        if (pins.ale && pins.p0_oe) begin
            addr_lo <= pins.p0_out;
        end
        if (!pins.wr_n && pins.p0_oe && !pins.ale) begin
            mem[addr] <= pins.p0_out;
        end
        last <= port0_in;
    end
endmodule
`default_nettype wire

// [ext_memory_strobe_reset_pins_tb.sv]
// self-checking testbench for the external memory strobe and reset pin block
`timescale 1ns/1ps
`default_nettype none
module ext_memory_strobe_reset_pins_tb;
    // ***************************************************************
    // stimulus and observed signals
    // ***************************************************************
    logic               clock = 1'b0;
    logic               rst_n = 1'b0;
    logic               pin_drv = 1'b0;
    logic               external_access_select = 1'b0;
    logic               port3_bit5 = 1'b1;
    logic               wdt_overflow = 1'b0;
    logic [15:0]        fetch_addr = 16'h0100;
    logic               xdata_req = 1'b0;
    emc_pkg::emc_xreq_t xreq = '0;
    emc_pkg::emc_pins_t pins;
    emc_pkg::emc_pins_t prev = emc_pkg::PINS_IDLE;
    logic               reset_pin_out;
    logic               reset_pin_oe;
    wire logic          reset_pin_level;
    logic               cpu_reset;
    logic               ext_fetch;
    logic               second_timer_count_input;
    logic               xdata_done;
    logic [7:0]         xdata_rdata;
    logic [7:0]         port0_in;
    int                 error_cnt = 0;
    int                 total_checks = 0;
    int                 ale_cnt = 0;
    int                 program_store_read_strobe_cnt = 0;
    int                 wr_cnt = 0;
    int                 rd_cnt = 0;

    always #5 clock = ~clock;

    // external drive pin_drv on the reset pin, device drive wins
    assign reset_pin_level = reset_pin_oe ? reset_pin_out : pin_drv;

    emc_ctrl uut (
        .clock(clock), .rst_n(rst_n), .reset_pin_in(reset_pin_level), .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe), .external_access_select(external_access_select),
        .port3_bit5(port3_bit5), .port0_in(port0_in), .wdt_overflow(wdt_overflow),
        .fetch_addr(fetch_addr), .xdata_req(xdata_req), .xreq(xreq), .pins(pins),
        .cpu_reset(cpu_reset), .ext_fetch(ext_fetch), .second_timer_count_input(second_timer_count_input),
        .xdata_done(xdata_done), .xdata_rdata(xdata_rdata)
    );

    emc_mem_model mem_model (.clock(clock), .pins(pins), .port0_in(port0_in));

    // edge counters on the strobe pins, sampled before the edge updates land
    always @(posedge clock) begin
        if (pins.ale === 1'b1 && prev.ale === 1'b0) ale_cnt++;
        if (pins.program_store_read_strobe_n === 1'b0 && prev.program_store_read_strobe_n === 1'b1) program_store_read_strobe_cnt++;
        if (pins.wr_n === 1'b0 && prev.wr_n === 1'b1) wr_cnt++;
        if (pins.rd_n === 1'b0 && prev.rd_n === 1'b1) rd_cnt++;
        prev = pins;
    end

    // ***************************************************************
    // shared tasks
    // ***************************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset(input logic ea);
        @(negedge clock);
        rst_n = 1'b0;
        external_access_select = ea;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        external_access_select = ~ea;
    endtask

    // ten machine cycles, optionally with one data access inside
    task automatic window(input logic acc, input logic wr, input logic [15:0] a, input logic [7:0] d,
                          input int exp_ale, input int exp_program_store_read_strobe);
        int a0, p0, w0, r0, done, i;
        a0 = ale_cnt;
        p0 = program_store_read_strobe_cnt;
        w0 = wr_cnt;
        r0 = rd_cnt;
        done = 0;
        if (acc) begin
            xreq = '{wr: wr, addr: a, wdata: d};
            xdata_req = 1'b1;
        end
        for (i = 0; i < 120; i++) begin
            @(negedge clock);
            if (xdata_req && (pins.wr_n === 1'b0 || pins.rd_n === 1'b0)) xdata_req = 1'b0;
            if (xdata_done === 1'b1) done++;
        end
        chk("ale pulses", 16'(exp_ale), 16'(ale_cnt - a0));
        chk("program_store_read_strobe pulses", 16'(exp_program_store_read_strobe), 16'(program_store_read_strobe_cnt - p0));
        chk("write strobes", 16'(acc && wr), 16'(wr_cnt - w0));
        chk("read strobes", 16'(acc && !wr), 16'(rd_cnt - r0));
        chk("data done", 16'(acc), 16'(done));
    endtask

    // design output by code: 0 timer pulse, 1 reset pin drive, other core reset
    function automatic logic pick(input int which);
        case (which)
            0:       pick = second_timer_count_input;
            1:       pick = reset_pin_oe;
            default: pick = cpu_reset;
        endcase
    endfunction

    task automatic wait_for(input int which, input logic lvl, input int lim, output int n);
        n = 0;
        while (pick(which) !== lvl && n < lim) begin
            @(negedge clock);
            n++;
        end
    endtask

    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic s_ext_code_and_data;
        do_reset(1'b0);
        window(1'b0, 1'b0, 16'h0000, 8'h00, 20, 20);
        chk("ext fetch low select", 1'b1, ext_fetch);
        window(1'b1, 1'b1, 16'h1234, 8'ha5, 19, 18);
        chk("latched write", 8'ha5, mem_model.mem[16'h1234]);
        window(1'b1, 1'b0, 16'h1234, 8'h00, 19, 18);
        chk("read data", 8'ha5, xdata_rdata);
    endtask

    task automatic s_timer_input;
        int n;
        port3_bit5 = 1'b0;
        wait_for(0, 1'b1, 10, n);
        chk("timer count pulse", 1'b1, second_timer_count_input);
        port3_bit5 = 1'b1;
        repeat (8) @(negedge clock);
    endtask

    task automatic s_watchdog;
        int n;
        wdt_overflow = 1'b1;
        @(negedge clock);
        wdt_overflow = 1'b0;
        wait_for(1, 1'b1, 4, n);
        chk("pin drive value", 1'b1, reset_pin_out);
        chk("core reset during drive", 1'b1, cpu_reset);
        wait_for(1, 1'b0, 40, n);
        chk("pin drive length", 16'(emc_pkg::WDT_RST_CYC), 16'(n));
        repeat (4) @(negedge clock);
        chk("core reset after drive", 1'b0, cpu_reset);
    endtask

    task automatic s_int_code;
        do_reset(1'b1);
        fetch_addr = 16'h7fff;
        window(1'b0, 1'b0, 16'h0000, 8'h00, 20, 0);
        chk("int fetch at top", 1'b0, ext_fetch);
        fetch_addr = 16'h8000;
        window(1'b0, 1'b0, 16'h0000, 8'h00, 20, 20);
        chk("ext fetch above top", 1'b1, ext_fetch);
    endtask

    task automatic s_pin_reset;
        int n;
        fetch_addr = 16'h0100;
        pin_drv = 1'b1;
        repeat (20) @(negedge clock);
        chk("short pin pulse", 1'b0, cpu_reset);
        pin_drv = 1'b0;
        repeat (8) @(negedge clock);
        pin_drv = 1'b1;
        wait_for(2, 1'b1, 40, n);
        chk("pin reset delay ok", 1'b1, n >= emc_pkg::RST_HOLD_CYC && n <= 30);
        pin_drv = 1'b0;
        wait_for(2, 1'b0, 12, n);
        chk("pin reset release", 1'b0, cpu_reset);
        repeat (3) @(negedge clock);
        chk("resampled low select", 1'b1, ext_fetch);
    endtask

    // ***************************************************************
    // run control
    // ***************************************************************
    task automatic results;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        s_ext_code_and_data();
        s_timer_input();
        s_watchdog();
        s_int_code();
        s_pin_reset();
        results();
    end

    // about 740 cycles expected
    initial begin
        #100000;
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire
